// ---- verilog/pes_sequencer.sv ----
`timescale 1ns/10ps
`include "pes_defs.svh"
module pes_sequencer
  import pes_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int CAUSE_W = 32,
  parameter logic [`PES_VEC_W-1:0] SMI_VECTOR = 20'h01400,
  parameter logic [`PES_VEC_W-1:0] DEC_VECTOR = 20'h00900,
  parameter logic [ADDR_W-1:0] VECTOR_BASE = '0
) (
  input wire logic clk, // processor clock
  input wire logic reset_n, // async reset, active low
  input wire logic softResetPin, // soft reset request
  input wire logic hardResetPin, // hard reset request
  input wire logic machineCheckPin, // machine check request
  input wire logic transferErrorAck, // bus transfer error
  input wire logic dataTransaction, // data bus tenure active
  input wire logic parityError, // address or data parity fault
  input wire logic intRequestPin, // external interrupt level
  input wire logic smiEvent, // system management pulse
  input wire logic decEvent, // decrementer pulse
  input wire logic cmpValid, // instruction in completion stage
  input wire logic cmpExc, // that instruction faults
  input wire logic cmpTrapSc, // fault is trap or system call
  input wire logic [`PES_VEC_W-1:0] cmpVector, // vector of the fault
  input wire logic [1:0] cmpCauseSel, // which cause register
  input wire logic [CAUSE_W-1:0] cmpCause, // specific cause bits
  input wire logic [ADDR_W-1:0] cmpAddr, // its address
  input wire logic [ADDR_W-1:0] cmpNextAddr, // following address
  input wire logic execBusy, // execution units occupied
  input wire logic restartKnown, // fetch restart address valid
  input wire logic [ADDR_W-1:0] restartAddr, // fetch restart address
  input wire logic storeQueueEmpty, // completed store queue drained
  input wire logic rfiStrobe, // handler return
  input wire logic [ADDR_W-1:0] rfiTarget, // handler resume address
  input wire logic msrWrite, // software msr write
  input wire logic [`PES_MSR_W-1:0] msrWrData, // msr write data
  input wire logic enableWrite, // enable control write
  input wire logic [`PES_EN_W-1:0] enableData, // enable write data
  input wire logic fpModeWrite, // fp exception mode write
  input wire logic [1:0] fpModeData, // fp exception mode
  output logic cmpHold, // block completion
  output logic cmpFlush, // kill faulting and younger
  output logic fetchRedirect, // one-cycle redirect pulse
  output logic [ADDR_W-1:0] fetchAddr, // redirect target
  output logic [ADDR_W-1:0] savedRestartAddr, // saved restart address
  output logic [`PES_MSR_W-1:0] savedState, // saved machine state
  output logic [`PES_MSR_W-1:0] machineState, // machine state register
  output logic [CAUSE_W-1:0] dataFaultCause, // data fault cause
  output logic [CAUSE_W-1:0] fpStatusCause, // fp status cause
  output logic [`PES_EN_W-1:0] excEnable, // enable controls
  output logic [1:0] fpMode, // stored fp mode
  output logic excActive // handler in progress
);
  pes_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] fetchAddr_ff, nxt_fetchAddr;
  logic [ADDR_W-1:0] srr_ff, nxt_srr;
  logic [ADDR_W-1:0] bndAddr_ff, nxt_bndAddr;
  logic [`PES_MSR_W-1:0] ss_ff, nxt_ss, msr_ff, nxt_msr;
  logic [CAUSE_W-1:0] dfc_ff, nxt_dfc, fpc_ff, nxt_fpc;
  logic [`PES_EN_W-1:0] en_ff, nxt_en;
  logic [1:0] fpm_ff, nxt_fpm;
  logic redir_ff, nxt_redir;
  logic bnd_ff, nxt_bnd;
  logic nmLvl_ff, nxt_nmLvl;
  logic smiPend_ff, nxt_smiPend, decPend_ff, nxt_decPend;
  logic rstReq, mcReq, nmReq, nmEdge, extReq, maskPend;
  logic syncTake, asyncTake, takeNow, bndNow, isFp;
  logic [`PES_SRC_N-1:0] srcReq, srcGrant;
  logic srcAny;
  logic [`PES_VEC_W-1:0] takeVec;
  logic [ADDR_W-1:0] takeAddr;

  // nonmaskable sources
  assign rstReq = softResetPin | hardResetPin;
  assign mcReq = (transferErrorAck & dataTransaction & en_ff[`PES_EN_TEA]) | machineCheckPin
    | (parityError & en_ff[`PES_EN_PAR]);
  assign nmReq = rstReq | mcReq;
  assign nmEdge = nmReq & ~nmLvl_ff;
  // maskable sources, and the request vector for all five sources
  assign extReq = intRequestPin & msr_ff[`PES_MSR_EE];
  assign srcReq[`PES_SRC_RST] = rstReq & nmEdge;
  assign srcReq[`PES_SRC_MC] = mcReq & nmEdge;
  assign srcReq[`PES_SRC_EXT] = extReq;
  assign srcReq[`PES_SRC_SMI] = smiPend_ff & msr_ff[`PES_MSR_EE];
  assign srcReq[`PES_SRC_DEC] = decPend_ff & msr_ff[`PES_MSR_EE];
  assign maskPend = |srcReq[`PES_SRC_DEC:`PES_SRC_EXT];

  pes_prio_pick #(
    .N(`PES_SRC_N)
  ) u_pick (
    .req(srcReq),
    .grant(srcGrant),
    .any(srcAny)
  );

  // fp faults gated by enable; mode setting never changes this
  assign isFp = cmpCauseSel == `PES_CAUSE_FP;
  assign syncTake = cmpValid & cmpExc & ~(isFp & ~en_ff[`PES_EN_FP]);
  // boundary for maskable: next instruction completes, or pipe empty
  assign bndNow = (cmpValid & ~cmpExc) | (~cmpValid & ~execBusy & restartKnown);

  // take decision
  always_comb
  begin
    asyncTake = 1'b0;
    takeNow = 1'b0;
    case (state_ff)
      PES_IDLE:
      begin
        takeNow = nmEdge | syncTake;
      end
      PES_DRAIN:
      begin
        asyncTake = maskPend & (bnd_ff | bndNow) & ~syncTake & storeQueueEmpty;
        takeNow = nmEdge | syncTake | asyncTake;
      end
      PES_HANDLER:
      begin
        takeNow = nmEdge;
      end
      default:
      begin
        takeNow = 1'b0;
      end
    endcase
  end

  // vector and saved address of the exception being taken
  always_comb
  begin
    takeVec = cmpVector;
    takeAddr = cmpTrapSc ? cmpNextAddr : cmpAddr;
    if (nmEdge)
    begin
      takeVec = srcGrant[`PES_SRC_RST] ? `PES_VEC_SOFT_RESET_PIN : `PES_VEC_MCHECK;
      takeAddr = cmpValid ? cmpAddr : restartAddr;
    end
    else if (!syncTake)
    begin
      takeVec = srcGrant[`PES_SRC_EXT] ? `PES_VEC_EXTINT :
        (srcGrant[`PES_SRC_SMI] ? SMI_VECTOR : DEC_VECTOR);
      takeAddr = bnd_ff ? bndAddr_ff : (cmpValid ? cmpNextAddr : restartAddr);
    end
  end

  // completion stage control
  assign cmpHold = state_ff == PES_HANDLER | bnd_ff | takeNow;
  assign cmpFlush = takeNow;

  // sequencing state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_bnd = bnd_ff;
    nxt_bndAddr = bndAddr_ff;
    if (takeNow)
    begin
      nxt_state = PES_HANDLER;
      nxt_bnd = 1'b0;
    end
    else
    begin
      case (state_ff)
        PES_IDLE:
        begin
          if (maskPend)
          begin
            nxt_state = PES_DRAIN;
          end
        end
        PES_DRAIN:
        begin
          if (!maskPend)
          begin
            nxt_state = PES_IDLE;
            nxt_bnd = 1'b0;
          end
          else if (!bnd_ff && bndNow)
          begin
            nxt_bnd = 1'b1;
            nxt_bndAddr = cmpValid ? cmpNextAddr : restartAddr;
          end
        end
        PES_HANDLER:
        begin
          if (rfiStrobe)
          begin
            nxt_state = PES_IDLE;
          end
        end
        default:
        begin
          nxt_state = PES_IDLE;
          nxt_bnd = 1'b0;
        end
      endcase
    end
  end

  // fetch redirect and save registers
  always_comb
  begin
    nxt_redir = 1'b0;
    nxt_fetchAddr = fetchAddr_ff;
    nxt_srr = srr_ff;
    nxt_ss = ss_ff;
    nxt_msr = msr_ff;
    if (takeNow)
    begin
      nxt_redir = 1'b1;
      nxt_fetchAddr = VECTOR_BASE | {{(ADDR_W-`PES_VEC_W){1'b0}}, takeVec};
      nxt_srr = takeAddr;
      nxt_ss = msr_ff;
      nxt_msr[`PES_MSR_SUP] = 1'b1;
      nxt_msr[`PES_MSR_EE] = 1'b0;
      // nonmaskable inside a handler loses the saved state
      nxt_msr[`PES_MSR_RI] = nmEdge ? (state_ff != PES_HANDLER) & msr_ff[`PES_MSR_RI]
        : 1'b1;
    end
    else if (state_ff == PES_HANDLER && rfiStrobe)
    begin
      nxt_redir = 1'b1;
      nxt_fetchAddr = rfiTarget;
      nxt_msr = ss_ff;
    end
    else if (msrWrite)
    begin
      nxt_msr = msrWrData;
    end
  end

  // cause registers, enables and pending events
  always_comb
  begin
    nxt_dfc = dfc_ff;
    nxt_fpc = fpc_ff;
    nxt_en = enableWrite ? enableData : en_ff;
    nxt_fpm = fpModeWrite ? fpModeData : fpm_ff;
    nxt_nmLvl = nmReq;
    if (takeNow && !nmEdge && syncTake)
    begin
      if (cmpCauseSel == `PES_CAUSE_DATA)
      begin
        nxt_dfc = cmpCause;
      end
      if (isFp)
      begin
        nxt_fpc = cmpCause;
      end
    end
    // set wins over clear on the same cycle
    nxt_smiPend = (smiPend_ff & ~(asyncTake & srcGrant[`PES_SRC_SMI]))
      | (smiEvent & en_ff[`PES_EN_SMI]);
    nxt_decPend = (decPend_ff & ~(asyncTake & srcGrant[`PES_SRC_DEC]))
      | (decEvent & en_ff[`PES_EN_DEC]);
  end

  // register all state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= PES_IDLE;
      bnd_ff <= 1'b0;
      bndAddr_ff <= '0;
      redir_ff <= 1'b0;
      fetchAddr_ff <= '0;
      srr_ff <= '0;
      ss_ff <= '0;
      msr_ff <= `PES_MSR_RST;
      dfc_ff <= '0;
      fpc_ff <= '0;
      en_ff <= `PES_EN_RST;
      fpm_ff <= `PES_FPM_RST;
      nmLvl_ff <= 1'b0;
      smiPend_ff <= 1'b0;
      decPend_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      bnd_ff <= nxt_bnd;
      bndAddr_ff <= nxt_bndAddr;
      redir_ff <= nxt_redir;
      fetchAddr_ff <= nxt_fetchAddr;
      srr_ff <= nxt_srr;
      ss_ff <= nxt_ss;
      msr_ff <= nxt_msr;
      dfc_ff <= nxt_dfc;
      fpc_ff <= nxt_fpc;
      en_ff <= nxt_en;
      fpm_ff <= nxt_fpm;
      nmLvl_ff <= nxt_nmLvl;
      smiPend_ff <= nxt_smiPend;
      decPend_ff <= nxt_decPend;
    end
  end

  // outputs
  assign fetchRedirect = redir_ff;
  assign fetchAddr = fetchAddr_ff;
  assign savedRestartAddr = srr_ff;
  assign savedState = ss_ff;
  assign machineState = msr_ff;
  assign dataFaultCause = dfc_ff;
  assign fpStatusCause = fpc_ff;
  assign excEnable = en_ff;
  assign fpMode = fpm_ff;
  assign excActive = state_ff == PES_HANDLER;

  if (ADDR_W < `PES_VEC_W || CAUSE_W < 1)
  begin : g_chk
    $error("pes_sequencer address must hold a vector offset");
  end
endmodule // pes_sequencer

// ---- inc/pes_defs.svh ----
`ifndef PES_DEFS_SVH
`define PES_DEFS_SVH
// exception vector offsets
`define PES_VEC_SOFT_RESET_PIN 20'h00100
`define PES_VEC_MCHECK 20'h00200
`define PES_VEC_EXTINT 20'h00500
`define PES_VEC_W 20
// machine state register layout
`define PES_MSR_W 3
`define PES_MSR_SUP 2
`define PES_MSR_EE 1
`define PES_MSR_RI 0
`define PES_MSR_RST 3'h5
// asynchronous source indices, highest priority first
`define PES_SRC_N 5
`define PES_SRC_RST 0
`define PES_SRC_MC 1
`define PES_SRC_EXT 2
`define PES_SRC_SMI 3
`define PES_SRC_DEC 4
// enable control layout
`define PES_EN_W 5
`define PES_EN_FP 0
`define PES_EN_SMI 1
`define PES_EN_DEC 2
`define PES_EN_PAR 3
`define PES_EN_TEA 4
`define PES_EN_RST 5'h1f
// stored fp exception mode after reset
`define PES_FPM_RST 2'h0
// cause selector codes
`define PES_CAUSE_NONE 2'h0
`define PES_CAUSE_DATA 2'h1
`define PES_CAUSE_FP 2'h2
`endif

// ---- inc/pes_pkg.sv ----
package pes_pkg;
  typedef enum logic [1:0] {PES_IDLE, PES_DRAIN, PES_HANDLER} pes_state_t;
endpackage

// ---- verilog/pes_prio_pick.sv ----
`timescale 1ns/10ps
// fixed priority picker, bit 0 wins
module pes_prio_pick #(
  parameter int N = 5
) (
  input wire logic [N-1:0] req, // requests
  output logic [N-1:0] grant, // one-hot winner
  output logic any // some request present
);
  logic [N:0] blocked;

  // prefix chain of lower-index requests
  assign blocked[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_pick
      assign grant[i] = req[i] & ~blocked[i];
      assign blocked[i+1] = blocked[i] | req[i];
    end
  endgenerate
  assign any = blocked[N];

  if (N < 1)
  begin : g_chk
    $error("pes_prio_pick needs at least one request");
  end
endmodule // pes_prio_pick

// ---- dv/pes_far_model.sv ----
`timescale 1ns/10ps
// completion side model: store queue drain and restart address
module pes_far_model #(
  parameter logic [31:0] RESTART = 32'h00002f40
) (
  input wire logic clk, // processor clock
  input wire logic reset_n, // async reset, active low
  input wire logic [2:0] sqPush, // stores entering the queue
  input wire logic execBusy, // execution units occupied
  output logic storeQueueEmpty, // queue drained
  output logic restartKnown, // restart address valid
  output logic [31:0] restartAddr // restart address
);
  logic [3:0] sqCnt_ff, nxt_sqCnt;
  logic known_ff, nxt_known;
  // one store leaves per cycle, address settles a cycle after units empty
  always_comb
  begin
    nxt_sqCnt = sqCnt_ff + 4'(sqPush) - 4'(sqCnt_ff != 4'h0);
    nxt_known = !execBusy;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sqCnt_ff <= 4'h0;
      known_ff <= 1'b0;
    end
    else
    begin
      sqCnt_ff <= nxt_sqCnt;
      known_ff <= nxt_known;
    end
  end
  // address shows garbage while not known
  assign storeQueueEmpty = (sqCnt_ff == 4'h0);
  assign restartKnown = known_ff && !execBusy;
  assign restartAddr = restartKnown ? RESTART : ~RESTART;
endmodule // pes_far_model

// ---- dv/pes_sequencer_properties.sv ----
`timescale 1ns/10ps
// port-level checks of the sequencer
module pes_properties (
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire logic softResetPin, // soft reset
  input wire logic hardResetPin, // hard reset
  input wire logic machineCheckPin, // check pin
  input wire logic transferErrorAck, // bus error
  input wire logic dataTransaction, // data tenure
  input wire logic parityError, // parity fault
  input wire logic cmpValid, // completing
  input wire logic cmpExc, // faulting
  input wire logic storeQueueEmpty, // queue empty
  input wire logic rfiStrobe, // return
  input wire logic [31:0] rfiTarget, // return target
  input wire logic cmpHold, // hold
  input wire logic cmpFlush, // flush
  input wire logic fetchRedirect, // redirect
  input wire logic [31:0] fetchAddr, // target
  input wire logic [2:0] machineState, // msr
  input wire logic [4:0] excEnable, // enables
  input wire logic excActive // in handler
);
  logic nm;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // combined nonmaskable request
  assign nm = softResetPin | hardResetPin | machineCheckPin | parityError & excEnable[3]
    | transferErrorAck & dataTransaction & excEnable[4];
  a_take_redirect: assert property (cmpFlush |=> fetchRedirect && machineState[2:1] == 2'b10)
    else $error("take without supervisor redirect");
  a_flush_holds: assert property (cmpFlush |-> cmpHold)
    else $error("flush without hold");
  a_handler_holds: assert property (excActive |-> cmpHold)
    else $error("completion open inside handler");
  a_single_exc: assert property (excActive && cmpFlush |-> $rose(nm))
    else $error("take inside handler");
  a_reset_vec: assert property ($rose(nm) && (softResetPin || hardResetPin)
    |=> fetchRedirect && fetchAddr == 32'h00000100)
    else $error("reset vector wrong");
  a_mcheck_vec: assert property ($rose(nm) && !softResetPin && !hardResetPin
    |=> fetchRedirect && fetchAddr == 32'h00000200)
    else $error("machine check vector wrong");
  a_ext_enable: assert property (fetchRedirect && fetchAddr == 32'h00000500 && !$past(excActive)
    |-> $past(machineState[1]))
    else $error("external taken while masked");
  a_async_drained: assert property (cmpFlush && !excActive && !(cmpValid && cmpExc) && !$rose(nm)
    |-> storeQueueEmpty)
    else $error("async take with stores queued");
  a_rfi_return: assert property (excActive && rfiStrobe && !$rose(nm)
    |=> fetchRedirect && !excActive && fetchAddr == $past(rfiTarget))
    else $error("return target wrong");
  c_return: cover property (excActive && rfiStrobe);
  c_nonmask: cover property ($rose(nm));
  c_async: cover property (cmpFlush && !cmpExc && storeQueueEmpty);
endmodule // pes_properties
bind pes_sequencer pes_properties u_props (.clk, .reset_n, .softResetPin, .hardResetPin,
  .machineCheckPin, .transferErrorAck, .dataTransaction, .parityError, .cmpValid, .cmpExc,
  .storeQueueEmpty, .rfiStrobe, .rfiTarget, .cmpHold, .cmpFlush, .fetchRedirect, .fetchAddr,
  .machineState, .excEnable, .excActive);

// ---- dv/precise_exception_sequencer_tb.sv ----
`timescale 1ns/10ps
// self-checking bench for the exception sequencer
module precise_exception_sequencer_tb;
  import pes_pkg::*;
  localparam logic [31:0] RST_ADDR = 32'h00002f40;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic softResetPin, hardResetPin, machineCheckPin, transferErrorAck, dataTransaction;
  logic parityError, intRequestPin, smiEvent, decEvent, cmpValid, cmpExc, cmpTrapSc;
  logic execBusy, rfiStrobe, msrWrite, enableWrite, fpModeWrite, restartKnown;
  logic storeQueueEmpty, cmpHold, cmpFlush, fetchRedirect, excActive;
  logic [19:0] cmpVector;
  logic [1:0] cmpCauseSel, fpModeData, fpMode;
  logic [31:0] cmpCause, cmpAddr, cmpNextAddr, rfiTarget, restartAddr, fetchAddr;
  logic [31:0] savedRestartAddr, dataFaultCause, fpStatusCause, r;
  logic [2:0] msrWrData, sqPush, savedState, machineState;
  logic [4:0] enableData, excEnable;
  logic [4:0] nmMask [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h09};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 32'h56cd;
  pes_sequencer dut (.*);
  pes_far_model #(.RESTART(RST_ADDR)) far (.*);
  always #5 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] exp_saved(logic trap, logic [31:0] a, logic [31:0] n);
    return trap ? n : a;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_take();
    for (int i = 0; i < 30 && cmpFlush !== 1'b1; i++)
      @(negedge clk);
    chk("take", cmpFlush, 1'b1);
    @(negedge clk);
  endtask
  task automatic sync_fault(input logic [19:0] vec, input logic [1:0] sel, input logic trap);
    logic [2:0] machine_state_register;
    machine_state_register = machineState;
    @(negedge clk);
    {cmpValid, cmpExc, cmpTrapSc, cmpVector, cmpCauseSel} = {2'b11, trap, vec, sel};
    cmpAddr = $random(seed);
    cmpNextAddr = cmpAddr + 32'h4;
    cmpCause = $random(seed);
    #1 chk("flush", cmpFlush, 1'b1);
    @(negedge clk);
    {cmpValid, cmpExc} = 2'b00;
    chk("redirect", fetchAddr, {12'h000, vec});
    chk("saved addr", savedRestartAddr, exp_saved(trap, cmpAddr, cmpNextAddr));
    chk("saved state", savedState, machine_state_register);
    chk("msr", machineState, 3'h5);
    chk("cause", (sel == 2'h1) ? dataFaultCause : fpStatusCause, cmpCause);
  endtask
  task automatic rfi(input logic [31:0] t);
    logic [2:0] st;
    st = savedState;
    @(negedge clk);
    {rfiStrobe, rfiTarget} = {1'b1, t};
    @(negedge clk);
    rfiStrobe = 1'b0;
    chk("return", fetchAddr, t);
    chk("return msr", machineState, st);
  endtask
  // main sequence
  initial
  begin
    {softResetPin, hardResetPin, machineCheckPin, transferErrorAck, dataTransaction} = '0;
    {parityError, intRequestPin, smiEvent, decEvent, cmpValid, cmpExc, cmpTrapSc} = '0;
    {execBusy, rfiStrobe, msrWrite, enableWrite, fpModeWrite, cmpVector, cmpCauseSel} = '0;
    {fpModeData, cmpCause, cmpAddr, cmpNextAddr, rfiTarget, msrWrData, sqPush, enableData} = '0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    chk("reset msr", machineState, 3'h5);
    chk("reset enables", excEnable, 5'h1f);
    for (int k = 0; k < 6; k++)
    begin
      r = $random(seed);
      sync_fault(r[0] ? 20'h00600 : 20'h00700, 2'h1 + 2'(r[1]), r[2]);
      rfi($random(seed));
    end
    @(negedge clk);
    {enableWrite, enableData, fpModeWrite, fpModeData} = {1'b1, 5'h1e, 1'b1, 2'h3};
    @(negedge clk);
    {enableWrite, fpModeWrite, cmpValid, cmpExc, cmpCauseSel} = {4'b0011, 2'h2};
    #1 chk("fp disabled", cmpFlush, 1'b0);
    chk("fp mode", fpMode, 2'h3);
    @(negedge clk);
    {cmpValid, cmpExc, enableWrite, enableData} = {3'b001, 5'h1f};
    sync_fault(20'h00800, 2'h2, 1'b0);
    enableWrite = 1'b0;
    rfi(32'h00001000);
    intRequestPin = 1'b1;
    repeat (4) @(negedge clk);
    chk("masked", excActive, 1'b0);
    {msrWrite, msrWrData, sqPush, cmpValid, cmpExc} = {1'b1, 3'h7, 3'h3, 2'b10};
    cmpNextAddr = $random(seed);
    @(negedge clk);
    {msrWrite, sqPush} = '0;
    wait_take();
    chk("ext vector", fetchAddr, 32'h00000500);
    chk("ext saved", savedRestartAddr, cmpNextAddr);
    chk("ext msr", machineState, 3'h5);
    {intRequestPin, cmpValid} = 2'b00;
    rfi(32'h00002000);
    for (int j = 0; j < 2; j++)
    begin
      @(negedge clk);
      {smiEvent, decEvent} = (j == 0) ? 2'b10 : 2'b01;
      @(negedge clk);
      {smiEvent, decEvent} = 2'b00;
      // busy units keep the restart address unknown
      if (j == 1)
      begin
        execBusy = 1'b1;
        repeat (3) @(negedge clk);
        execBusy = 1'b0;
      end
      chk("busy wait", cmpFlush | excActive, 1'b0);
      wait_take();
      chk("async vector", fetchAddr, (j == 0) ? 32'h00001400 : 32'h00000900);
      chk("async saved", savedRestartAddr, RST_ADDR);
      rfi(32'h00003000);
    end
    // fault met while an interrupt drains goes first
    {smiEvent, sqPush} = {1'b1, 3'h3};
    @(negedge clk);
    {smiEvent, sqPush} = '0;
    @(negedge clk);
    sync_fault(20'h00700, 2'h1, 1'b0);
    rfi(32'h00005000);
    wait_take();
    chk("pending after fault", fetchAddr, 32'h00001400);
    rfi(32'h00003000);
    sync_fault(20'h00300, 2'h1, 1'b0);
    @(negedge clk);
    {cmpValid, cmpExc, dataTransaction} = 3'b111;
    #1 chk("second fault", cmpFlush, 1'b0);
    for (int m = 0; m < 6; m++)
    begin
      @(negedge clk);
      {cmpValid, cmpExc} = 2'b00;
      {hardResetPin, softResetPin, parityError, transferErrorAck, machineCheckPin} = nmMask[m];
      #1 chk("preempt", cmpFlush, 1'b1);
      @(negedge clk);
      chk("nm vector", fetchAddr, (nmMask[m][4:3] != 2'h0) ? 32'h100 : 32'h200);
      chk("ri", machineState[0], 1'b0);
      {hardResetPin, softResetPin, parityError, transferErrorAck, machineCheckPin} = '0;
    end
    dataTransaction = 1'b0;
    rfi(32'h00004000);
    wrap_up();
  end
endmodule // precise_exception_sequencer_tb
